// ---- bench/gpc_board.sv ----
// Board model for the port pads and the change notify pads.
// Assumes switchable pull-up resistors on change notify pads only; tb sets the far levels.
`timescale 1ns/1ps
module gpc_board
  import gpc_pkg::*;
(
  // Design side
  input  wire gpc_pin_drv_s         pin_drv,
  input  wire logic [GPC_CN_W-1:0]  cn_pullup_en,
  output logic      [GPC_PIN_W-1:0] pin_in,
  output logic      [GPC_CN_W-1:0]  cn_in,
  // Far side levels
  input  wire logic [GPC_PIN_W-1:0] ext_pin,
  input  wire logic [GPC_CN_W-1:0]  cn_ext,
  input  wire logic [GPC_CN_W-1:0]  cn_flt
);
  assign pin_in = (pin_drv.out & ~pin_drv.oe_n) | (ext_pin & pin_drv.oe_n);
  // floating pad pulled high
  // Without pull-up a floating pad flips, so it never reads a stale level
  assign cn_in = (cn_ext & ~cn_flt) | (cn_flt & (cn_pullup_en | ~cn_ext));
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the port pin and change notify block.
// Assumes the board model closes the pad loop.
`timescale 1ns/1ps
module tb
  import gpc_pkg::*;
;
  logic                 clk_sys;
  logic                 reset_n;
  logic [GPC_AW-1:0]    addr;
  logic [GPC_DW-1:0]    wdata;
  logic                 wr_en;
  logic                 rd_en;
  logic [GPC_DW-1:0]    rdata;
  logic [GPC_PIN_W-1:0] pin_in;
  logic [GPC_PIN_W-1:0] ext_pin;
  gpc_pin_drv_s         pin_drv;
  logic [GPC_CN_W-1:0]  cn_in;
  logic [GPC_CN_W-1:0]  cn_ext;
  logic [GPC_CN_W-1:0]  cn_flt;
  logic [GPC_CN_W-1:0]  cn_pullup_en;
  logic                 cn_wake;
  logic [GPC_CH_W-1:0]  conv_en;
  logic                 irq;
  logic [GPC_DW-1:0]    d;
  int                   fails = 0;
  int                   checked = 0;
  logic [GPC_AW-1:0]    ra [8] = '{GPC_REG_DIR, GPC_REG_LAT, GPC_REG_ODC,
    GPC_REG_ACFG_L1, GPC_REG_CNEN_HI, GPC_REG_CNPU_LO, GPC_REG_STAT,
    GPC_REG_MASK};

  gpc_port dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .pin_in(pin_in), .pin_drv(pin_drv), .cn_in(cn_in),
    .cn_pullup_en(cn_pullup_en), .cn_wake(cn_wake), .conv_en(conv_en),
    .irq(irq));

  gpc_board board_u (.pin_drv(pin_drv), .cn_pullup_en(cn_pullup_en),
    .pin_in(pin_in), .cn_in(cn_in), .ext_pin(ext_pin), .cn_ext(cn_ext),
    .cn_flt(cn_flt));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask

  // Callers start right after a rising edge; write leaves its strobe up
  task automatic wr(input logic [GPC_AW-1:0] a, input logic [GPC_DW-1:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [GPC_AW-1:0] a, output logic [GPC_DW-1:0] v);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [GPC_AW-1:0] a, input logic [GPC_DW-1:0] e,
                     input string nm);
    logic [GPC_DW-1:0] v;
    rd(a, v);
    chk(nm, {16'h0000, e}, {16'h0000, v});
  endtask

  task automatic nop(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  // Bounded wait for the interrupt line, sampled mid-cycle
  task automatic wait_irq();
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      if (irq === 1'b1) break;
    end
    @(posedge clk_sys);
    if (irq !== 1'b1) begin
      $display("mismatch irq wait exp 1 got %b", irq);
      fails++;
      print_verdict();
    end
  endtask

  initial begin
    reset_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ext_pin = 16'hc3a5;
    cn_ext = '0;
    cn_flt = '0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk("oe_n", 32'h0000_ffff, {16'h0000, pin_drv.oe_n});
    chk("conv_en", 32'hffff_ffff, conv_en);
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      rdc(ra[i], (i == 0) ? GPC_DIR_RST : 16'h0000, "reset reg");
    end
    rdc(GPC_REG_PORT, 16'h0000, "analog port");
    wr(GPC_REG_ACFG_L1, 16'hffff);
    wr(GPC_REG_ACFG_H1, 16'hffff);
    wr(GPC_REG_ACFG_H2, 16'hffff);
    // Analog channels read as zero in the port and feed conv_en while selected
    wr(GPC_REG_ACFG_L2, 16'hff0f);
    nop(4);
    chk("conv_en mix", 32'h0000_00f0, conv_en);
    rdc(GPC_REG_PORT, 16'hc305, "mixed port");
    wr(GPC_REG_ACFG_L2, 16'hffff);
    wr(GPC_REG_DIR, 16'hff00);
    wr(GPC_REG_LAT, 16'h005a);
    nop(4);
    chk("push out", 32'h0000_005a, {16'h0000, pin_drv.out});
    chk("push oe_n", 32'h0000_ff00, {16'h0000, pin_drv.oe_n});
    rdc(GPC_REG_PORT, 16'hc35a, "echo port");
    wr(GPC_REG_ODC, 16'h000f);
    wr(GPC_REG_LAT, 16'h0005);
    nop(4);
    chk("od out", 32'h0000_0000, {16'h0000, pin_drv.out});
    chk("od oe_n", 32'h0000_ff05, {16'h0000, pin_drv.oe_n});
    rdc(GPC_REG_PORT, 16'hc305, "od port");
    wr(GPC_REG_ODC, 16'h0000);
    wr(GPC_REG_MASK, 16'h0002);
    wr(GPC_REG_DIR, 16'hff00);
    rd(GPC_REG_PORT, d);
    rdc(GPC_REG_STAT, 16'h0002, "early read");
    @(negedge clk_sys);
    chk("irq early", 32'h1, {31'h0, irq});
    @(posedge clk_sys);
    wr(GPC_REG_STAT, 16'h0002);
    wr(GPC_REG_LAT, 16'h0001);
    nop(1);
    rd(GPC_REG_PORT, d);
    rdc(GPC_REG_STAT, 16'h0000, "spaced read");
    wr(GPC_REG_MASK, 16'h0001);
    wr(GPC_REG_CNEN_LO, 16'h0001);
    wr(GPC_REG_CNEN_HI, 16'h0080);
    nop(4);
    cn_ext[23] <= 1'b1;
    @(negedge clk_sys);
    chk("cn_wake", 32'h1, {31'h0, cn_wake});
    @(posedge clk_sys);
    wait_irq();
    rdc(GPC_REG_STAT, 16'h0001, "cn stat");
    wr(GPC_REG_STAT, 16'h0001);
    nop(1);
    @(negedge clk_sys);
    chk("irq clear", 32'h0, {31'h0, irq});
    chk("cn_wake idle", 32'h0, {31'h0, cn_wake});
    @(posedge clk_sys);
    cn_ext[5] <= 1'b1;
    nop(8);
    rdc(GPC_REG_STAT, 16'h0000, "cn disabled");
    cn_ext[0] <= 1'b0;
    wr(GPC_REG_MASK, 16'h0000);
    cn_ext[0] <= 1'b1;
    nop(8);
    @(negedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    @(posedge clk_sys);
    rdc(GPC_REG_STAT, 16'h0001, "cn pin0");
    wr(GPC_REG_MASK, 16'h0001);
    nop(1);
    @(negedge clk_sys);
    chk("irq unmask", 32'h1, {31'h0, irq});
    @(posedge clk_sys);
    wr(GPC_REG_CNPU_LO, 16'h8001);
    wr(GPC_REG_CNPU_HI, 16'hffff);
    wr(GPC_REG_STAT, 16'h0001);
    cn_flt <= 24'h01_0000;
    nop(2);
    @(negedge clk_sys);
    chk("pullup", 32'h00ff_8001, {8'h00, cn_pullup_en});
    chk("irq off", 32'h0, {31'h0, irq});
    @(posedge clk_sys);
    rdc(GPC_REG_CNPU_HI, 16'h00ff, "pullup hi");
    // Clear lands on the edge the settled change is flagged
    cn_ext[23] <= 1'b0;
    nop(3);
    wr(GPC_REG_STAT, 16'h0001);
    rdc(GPC_REG_STAT, 16'h0001, "set wins");
    wr(GPC_REG_PORT, 16'h0003);
    rdc(GPC_REG_LAT, 16'h0003, "port write");
    wr(GPC_REG_ACFG_L1, 16'hfffe);
    nop(1);
    chk("conv_en pin0", 32'h0000_0001, conv_en);
    wr(GPC_REG_ACFG_L1, 16'hffff);
    nop(1);
    chk("conv_en digital", 32'h0000_0000, conv_en);
    wr(4'he, 16'h1234);
    rdc(4'he, 16'h0000, "unmapped");
    print_verdict();
  end
endmodule

// ---- hw/gpc_pkg.sv ----
// Shared constants and types for the port pin and change notify block.
// Assumes a 16-bit register port with word addresses.
package gpc_pkg;

  // Widths
  localparam int GPC_PIN_W   = 16;
  localparam int GPC_CN_W    = 24;
  localparam int GPC_CN_LO_W = 16;
  localparam int GPC_CN_HI_W = GPC_CN_W - GPC_CN_LO_W;
  localparam int GPC_CH_W    = 32;
  localparam int GPC_DW      = 16;
  localparam int GPC_AW      = 4;
  localparam int GPC_IRQ_W   = 2;

  // Register word addresses
  localparam logic [GPC_AW-1:0] GPC_REG_DIR     = 4'h0;
  localparam logic [GPC_AW-1:0] GPC_REG_PORT    = 4'h1;
  localparam logic [GPC_AW-1:0] GPC_REG_LAT     = 4'h2;
  localparam logic [GPC_AW-1:0] GPC_REG_ODC     = 4'h3;
  localparam logic [GPC_AW-1:0] GPC_REG_ACFG_L1 = 4'h4;
  localparam logic [GPC_AW-1:0] GPC_REG_ACFG_H1 = 4'h5;
  localparam logic [GPC_AW-1:0] GPC_REG_ACFG_L2 = 4'h6;
  localparam logic [GPC_AW-1:0] GPC_REG_ACFG_H2 = 4'h7;
  localparam logic [GPC_AW-1:0] GPC_REG_CNEN_LO = 4'h8;
  localparam logic [GPC_AW-1:0] GPC_REG_CNEN_HI = 4'h9;
  localparam logic [GPC_AW-1:0] GPC_REG_CNPU_LO = 4'ha;
  localparam logic [GPC_AW-1:0] GPC_REG_CNPU_HI = 4'hb;
  localparam logic [GPC_AW-1:0] GPC_REG_STAT    = 4'hc;
  localparam logic [GPC_AW-1:0] GPC_REG_MASK    = 4'hd;

  // Reset values
  localparam logic [GPC_PIN_W-1:0] GPC_DIR_RST  = 16'hffff;
  localparam logic [GPC_PIN_W-1:0] GPC_LAT_RST  = 16'h0000;
  localparam logic [GPC_PIN_W-1:0] GPC_ODC_RST  = 16'h0000;
  localparam logic [GPC_DW-1:0]    GPC_ACFG_RST = 16'h0000;
  localparam logic [GPC_CN_W-1:0]  GPC_CN_RST   = 24'h00_0000;
  localparam logic [GPC_IRQ_W-1:0] GPC_IRQ_RST  = 2'h0;

  // Status bit positions
  localparam int GPC_IRQ_CN    = 0;
  localparam int GPC_IRQ_EARLY = 1;

  // Pin drive bundle; oe_n low while the pin is driven
  typedef struct packed {
    logic [GPC_PIN_W-1:0] out;
    logic [GPC_PIN_W-1:0] oe_n;
  } gpc_pin_drv_s;

endpackage

// ---- hw/gpc_port.sv ----
// I/O port pin logic with analog selection and change notification.
// Assumes pins are asynchronous and a converter outside reads conv_en.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module gpc_port
  import gpc_pkg::*;
#(
  parameter bit                  DUAL_ADC = 1'b1,
  parameter logic [GPC_CH_W-1:0] ANA_MASK = 32'hffff_ffff
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // Register port
  input  wire logic [GPC_AW-1:0]    addr,
  input  wire logic [GPC_DW-1:0]    wdata,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [GPC_DW-1:0]    rdata,
  // Port pins
  input  wire logic [GPC_PIN_W-1:0] pin_in,
  output gpc_pin_drv_s              pin_drv,
  // Change notify pins
  input  wire logic [GPC_CN_W-1:0]  cn_in,
  output logic      [GPC_CN_W-1:0]  cn_pullup_en,
  output logic                      cn_wake,
  // Converter and interrupt
  output logic      [GPC_CH_W-1:0]  conv_en,
  output logic                      irq
);

  // Register state
  logic [GPC_PIN_W-1:0] dir_q;
  logic [GPC_PIN_W-1:0] lat_q;
  logic [GPC_PIN_W-1:0] odc_q;
  logic [GPC_DW-1:0]    acfg_l1_q;
  logic [GPC_DW-1:0]    acfg_h1_q;
  logic [GPC_DW-1:0]    acfg_l2_q;
  logic [GPC_DW-1:0]    acfg_h2_q;
  logic [GPC_CN_W-1:0]  cnen_q;
  logic [GPC_CN_W-1:0]  cnpu_q;
  logic [GPC_IRQ_W-1:0] stat_q;
  logic [GPC_IRQ_W-1:0] stat_d;
  logic [GPC_IRQ_W-1:0] mask_q;
  logic [GPC_DW-1:0]    rdata_q;
  logic                 recent_q;
  logic [GPC_CN_W-1:0]  cn_last_q;

  // Synchronised inputs
  logic [GPC_PIN_W-1:0] pin_s2;
  logic [GPC_PIN_W-1:0] pin_s3;
  logic [GPC_CN_W-1:0]  cn_s2;
  logic [GPC_CN_W-1:0]  cn_s3;

  gpc_sync3 #(
    .W (GPC_PIN_W)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       (pin_in),
    .s2      (pin_s2),
    .s3      (pin_s3)
  );

  gpc_sync3 #(
    .W (GPC_CN_W)
  ) u_cn_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       (cn_in),
    .s2      (cn_s2),
    .s3      (cn_s3)
  );

  // Write decode
  wire logic wr_dir  = wr_en & (addr == GPC_REG_DIR);
  wire logic wr_port = wr_en & (addr == GPC_REG_PORT);
  wire logic wr_lat  = wr_en & (addr == GPC_REG_LAT);
  wire logic wr_odc  = wr_en & (addr == GPC_REG_ODC);
  wire logic wr_al1  = wr_en & (addr == GPC_REG_ACFG_L1);
  wire logic wr_ah1  = wr_en & (addr == GPC_REG_ACFG_H1);
  wire logic wr_al2  = wr_en & (addr == GPC_REG_ACFG_L2);
  wire logic wr_ah2  = wr_en & (addr == GPC_REG_ACFG_H2);
  wire logic wr_enlo = wr_en & (addr == GPC_REG_CNEN_LO);
  wire logic wr_enhi = wr_en & (addr == GPC_REG_CNEN_HI);
  wire logic wr_pulo = wr_en & (addr == GPC_REG_CNPU_LO);
  wire logic wr_puhi = wr_en & (addr == GPC_REG_CNPU_HI);
  wire logic wr_stat = wr_en & (addr == GPC_REG_STAT);
  wire logic wr_mask = wr_en & (addr == GPC_REG_MASK);
  wire logic rd_port = rd_en & (addr == GPC_REG_PORT);

  // Analog selection per converter channel
  logic [GPC_CH_W-1:0]  ana_m1;
  logic [GPC_CH_W-1:0]  ana_m2;
  logic [GPC_CH_W-1:0]  ch_ana;
  logic [GPC_PIN_W-1:0] pin_ana;
  assign ana_m1  = ~{acfg_h1_q, acfg_l1_q};
  assign ana_m2  = DUAL_ADC ? ~{acfg_h2_q, acfg_l2_q} : '0;
  assign ch_ana  = ANA_MASK & (ana_m1 | ana_m2);
  assign pin_ana = ch_ana[GPC_PIN_W-1:0];
  assign conv_en = ch_ana;

  // Port value seen by software
  logic [GPC_PIN_W-1:0] port_val;
  assign port_val = pin_s3 & ~pin_ana;

  assign pin_drv.out  = lat_q & ~odc_q;
  assign pin_drv.oe_n = dir_q | (odc_q & lat_q);

  // Change detection on settled levels
  logic [GPC_CN_W-1:0] cn_chg;
  logic                ev_cn;
  logic                ev_early;
  assign cn_chg = ~(cn_s2 ^ cn_s3) & (cn_s3 ^ cn_last_q);
  // only enabled pins raise the flag
  assign ev_cn  = |(cn_chg & cnen_q);
  // read too soon after port update
  assign ev_early = rd_port & recent_q;

  // Clockless wake path for sleep; raw pins against the latch.
  // wake without a running clock
  assign cn_wake = |((cn_in ^ cn_last_q) & cnen_q);

  assign cn_pullup_en = cnpu_q;

  // Read mux
  logic [GPC_DW-1:0] rd_mux;
  assign rd_mux =
    (addr == GPC_REG_DIR)     ? dir_q :
    (addr == GPC_REG_PORT)    ? port_val :
    (addr == GPC_REG_LAT)     ? lat_q :
    (addr == GPC_REG_ODC)     ? odc_q :
    (addr == GPC_REG_ACFG_L1) ? acfg_l1_q :
    (addr == GPC_REG_ACFG_H1) ? acfg_h1_q :
    (addr == GPC_REG_ACFG_L2) ? acfg_l2_q :
    (addr == GPC_REG_ACFG_H2) ? acfg_h2_q :
    (addr == GPC_REG_CNEN_LO) ? cnen_q[GPC_CN_LO_W-1:0] :
    (addr == GPC_REG_CNEN_HI) ?
      {{(GPC_DW-GPC_CN_HI_W){1'b0}}, cnen_q[GPC_CN_W-1:GPC_CN_LO_W]} :
    (addr == GPC_REG_CNPU_LO) ? cnpu_q[GPC_CN_LO_W-1:0] :
    (addr == GPC_REG_CNPU_HI) ?
      {{(GPC_DW-GPC_CN_HI_W){1'b0}}, cnpu_q[GPC_CN_W-1:GPC_CN_LO_W]} :
    (addr == GPC_REG_STAT)    ? {{(GPC_DW-GPC_IRQ_W){1'b0}}, stat_q} :
    (addr == GPC_REG_MASK)    ? {{(GPC_DW-GPC_IRQ_W){1'b0}}, mask_q} :
    '0;

  // Set wins over the write-one clear
  assign stat_d = (stat_q & ~(wr_stat ? wdata[GPC_IRQ_W-1:0] : '0))
                | {ev_early, ev_cn};

  // Port data and direction
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dir_q <= GPC_DIR_RST;
      lat_q <= GPC_LAT_RST;
      odc_q <= GPC_ODC_RST;
    end else begin
      if (wr_dir) begin
        dir_q <= wdata;
      end
      if (wr_lat | wr_port) begin
        lat_q <= wdata;
      end
      if (wr_odc) begin
        odc_q <= wdata;
      end
    end
  end

  // Analog configuration
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      acfg_l1_q <= GPC_ACFG_RST;
      acfg_h1_q <= GPC_ACFG_RST;
      acfg_l2_q <= GPC_ACFG_RST;
      acfg_h2_q <= GPC_ACFG_RST;
    end else begin
      if (wr_al1) begin
        acfg_l1_q <= wdata;
      end
      if (wr_ah1) begin
        acfg_h1_q <= wdata;
      end
      if (wr_al2) begin
        acfg_l2_q <= wdata;
      end
      if (wr_ah2) begin
        acfg_h2_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnen_q <= GPC_CN_RST;
      cnpu_q <= GPC_CN_RST;
    end else begin
      if (wr_enlo) begin
        cnen_q[GPC_CN_LO_W-1:0] <= wdata;
      end
      if (wr_enhi) begin
        cnen_q[GPC_CN_W-1:GPC_CN_LO_W] <= wdata[GPC_CN_HI_W-1:0];
      end
      if (wr_pulo) begin
        cnpu_q[GPC_CN_LO_W-1:0] <= wdata;
      end
      if (wr_puhi) begin
        cnpu_q[GPC_CN_W-1:GPC_CN_LO_W] <= wdata[GPC_CN_HI_W-1:0];
      end
    end
  end

  // Latch follows settled levels of every pin, enabled or not,
  // so enabling a pin later does not fire on stale history.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cn_last_q <= GPC_CN_RST;
    end else begin
      cn_last_q <= cn_last_q ^ cn_chg;
    end
  end

  // Status, mask, read data, write recency
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stat_q   <= GPC_IRQ_RST;
      mask_q   <= GPC_IRQ_RST;
      rdata_q  <= '0;
      recent_q <= 1'b0;
    end else begin
      stat_q   <= stat_d;
      rdata_q  <= rd_en ? rd_mux : '0;
      recent_q <= wr_dir | wr_lat | wr_port;
      if (wr_mask) begin
        mask_q <= wdata[GPC_IRQ_W-1:0];
      end
    end
  end

  assign rdata = rdata_q;
  assign irq   = |(stat_q & mask_q);

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  chk_od_release: assert property (
    (odc_q[0] && lat_q[0]) |-> pin_drv.oe_n[0] && !pin_drv.out[0])
    else $error("open drain pin driven high");

  chk_analog_reset: assert property (
    $past(!reset_n) |-> (conv_en == ANA_MASK))
    else $error("pins not analog after reset");

  chk_either_module: assert property (
    (wr_al1 && !wdata[0] && ANA_MASK[0]) |=> conv_en[0])
    else $error("cleared config bit did not select analog");

  chk_digital_noconv: assert property (
    (wr_al1 && wdata[0] && (!DUAL_ADC || acfg_l2_q[0]) && !wr_al2)
      |=> !conv_en[0])
    else $error("digital pin enabled to converter");

  chk_analog_read: assert property (
    (rd_port && pin_ana[0]) |=> (rdata[0] == 1'b0))
    else $error("analog pin read high");

  chk_early_read: assert property (
    (wr_dir ##1 rd_port) |=> stat_q[GPC_IRQ_EARLY])
    else $error("early port read not flagged");

  chk_cn_flag: assert property (
    (cn_chg[0] && cnen_q[0]) |=> stat_q[GPC_IRQ_CN] ##1 stat_q[GPC_IRQ_CN]
      || $past(wr_stat, 1))
    else $error("enabled change not flagged");

  chk_cn_latch: assert property (
    cn_chg[GPC_CN_W-1] |=> (cn_last_q[GPC_CN_W-1] == $past(cn_s3[GPC_CN_W-1])))
    else $error("change latch not updated");

  chk_pullup_write: assert property (
    wr_pulo |=> (cn_pullup_en[GPC_CN_LO_W-1:0] == $past(wdata)))
    else $error("pull-up enable not written");

  chk_set_wins: assert property (
    (ev_cn && wr_stat && wdata[GPC_IRQ_CN]) |=> stat_q[GPC_IRQ_CN])
    else $error("clear beat a change event");

  cov_cn_irq: cover property (ev_cn && mask_q[GPC_IRQ_CN] ##1 irq);
  cov_od_out: cover property (!dir_q[0] && odc_q[0] && lat_q[0]);
  cov_read_an: cover property (rd_port && pin_ana[0]);
  cov_early: cover property (wr_lat ##1 rd_port);

endmodule

// ---- hw/gpc_sync3.sv ----
// Three-stage synchroniser for a vector of asynchronous pins.
// Assumes each bit is independent; no bus coherency across bits.
`timescale 1ns/1ps
module gpc_sync3 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // Raw and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] s2,
  output logic      [W-1:0] s3
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign s2 = s2_q;
  assign s3 = s3_q;

endmodule
